//--- pkg/can_rx_cfg.svh
// constants for the receive buffering block
`ifndef CAN_RX_CFG_SVH
`define CAN_RX_CFG_SVH
`define ADDR_CTRL0    12'h000
`define ADDR_CTRL1    12'h004
`define ADDR_FLAGS    12'h008
`define ADDR_IRQEN    12'h00c
`define ADDR_MASK0    12'h010
`define ADDR_MASK1    12'h014
`define ADDR_FILT0    12'h020
`define ADDR_SLOT0    12'h100
`define ADDR_SLOT1    12'h140
`define SLOT_WORDS    4
`define CTRL_MODE_LSB 5
`define CTRL_RTR_BIT  3
`define CTRL_ROLL_BIT 2
`define FLAG_OVF_BIT  2
`define FILT_EXT_BIT  31
`define MODE_ALL      2'h0
`define MODE_STD      2'h1
`define MODE_EXT      2'h2
`define MODE_ANY      2'h3
`endif

//--- pkg/can_rx_pkg.sv
// types for the receive buffering block
package can_rx_pkg;
   // one frame as the assembly buffer holds it
   typedef struct packed {
      logic        ext;
      logic        rtr;
      logic [3:0]  dlc;
      logic [28:0] id;
      logic [63:0] data;
   } frame_t;
   typedef enum logic [1:0] {
      IDLE  = 2'b00,
      ASSEM = 2'b01,
      MOVE  = 2'b11
   } rx_state_t;
endpackage : can_rx_pkg

//--- hw/slot_mem.sv
// storage for the two receive slots, registered read
`timescale 1ns/1ps
module slot_mem
   import can_rx_pkg::*;
#(
   parameter int SLOTS = 2
) (
   input  wire logic        clk,
   input  wire logic        wrEn,
   input  wire logic        wrSlot,
   input  wire frame_t      wrFrame,
   input  wire logic        rdSlot,
   input  wire logic [1:0]  rdWord,
   output      logic [31:0] rdData
);
   frame_t mem [SLOTS];
   frame_t rdFrame;
   // whole frame overwritten on every load
   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrSlot] <= wrFrame;
      end
   end
   assign rdFrame = mem[rdSlot];
   // registered word select
   always_ff @(posedge clk) begin
      case (rdWord)
         2'h0:    rdData <= {3'h0, rdFrame.id};
         2'h1:    rdData <= {26'h0, rdFrame.ext, rdFrame.rtr, rdFrame.dlc};
         2'h2:    rdData <= rdFrame.data[31:0];
         default: rdData <= rdFrame.data[63:32];
      endcase
   end
endmodule : slot_mem

//--- hw/can_rx_buffer.sv
// receive buffering: assembly buffer, filters, two locked slots
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "can_rx_cfg.svh"
module can_rx_buffer
   import can_rx_pkg::*;
#(
   parameter int NFILT = 6
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire logic        frameStart,
   input  wire frame_t      frameIn,
   input  wire logic        frameDone,
   input  wire logic        frameError,
   output      logic        irq_out_n,
   output      logic        overflow
);
   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [1:0]  mode [2];
   logic        rollover;
   logic [3:0]  hitInfo [2];
   logic [1:0]  full;
   logic [1:0]  irqEn;
   logic [31:0] mask [2];
   logic [31:0] filt [NFILT];
   frame_t      assembly;
   rx_state_t   state;
   logic        access;
   logic        wrReq;
   logic        rdPhase;
   logic        slotRd;
   logic [31:0] memData;
   logic [31:0] regData;
   logic        regErr;
   logic        writeFull;
   logic [1:0]  clrFull;
   ////////////////////////////////////////////////////////////////////////
   // filter matching
   logic [NFILT-1:0] hit;
   logic             endOk;
   logic             endErr;
   logic             any0;
   logic             any1;
   logic             acc0;
   logic             acc1;
   logic [2:0]       idx0;
   logic [2:0]       idx1;
   logic             load;
   logic             loadSlot;
   logic             ovfEvt;
   logic [3:0]       loadHit;

   assign endOk  = (state == ASSEM) && frameDone;
   assign endErr = (state == ASSEM) && frameError;

   // per-filter compare under its slot mask
   always_comb begin
      for (int i = 0; i < NFILT; i++) begin
         automatic int s = (i < 2) ? 0 : 1;
         automatic logic [28:0] m = mask[s][28:0];
         automatic logic fe = filt[i][`FILT_EXT_BIT];
         automatic logic idOk;
         idOk = fe ? (((assembly.id ^ filt[i][28:0]) & m) == 29'h0)
                   : (((assembly.id[10:0] ^ filt[i][10:0]) & m[10:0]) == 11'h0);
         hit[i] = idOk && (fe == assembly.ext);
         if (mode[s] == `MODE_STD && fe) hit[i] = 1'b0;
         if (mode[s] == `MODE_EXT && !fe) hit[i] = 1'b0;
         if (mode[s] == `MODE_STD && assembly.ext) hit[i] = 1'b0;
         if (mode[s] == `MODE_EXT && !assembly.ext) hit[i] = 1'b0;
      end
   end

   // lowest matching filter index per slot
   always_comb begin
      idx0 = 3'h0;
      idx1 = 3'h2;
      if (!hit[0] && hit[1]) idx0 = 3'h1;
      for (int i = NFILT - 1; i >= 2; i--) begin
         if (hit[i]) idx1 = 3'(i);
      end
   end

   // acceptance and slot choice
   always_comb begin
      any0 = (mode[0] == `MODE_ANY) ? (endOk || endErr) : (endOk && |hit[1:0]);
      any1 = (mode[1] == `MODE_ANY) ? (endOk || endErr) : (endOk && |hit[NFILT-1:2]);
      acc0 = any0 && !full[0];
      acc1 = any1 && !full[1];
      load = 1'b0;
      loadSlot = 1'b0;
      loadHit = 4'h0;
      ovfEvt = 1'b0;
      if (acc0) begin
         load = 1'b1;
         loadHit = {assembly.rtr, 3'(idx0)};
      end else if (any0 && rollover && !full[1]) begin
         load = 1'b1;
         loadSlot = 1'b1;
         loadHit = {assembly.rtr, 3'(idx0)};
      end else if (acc1) begin
         load = 1'b1;
         loadSlot = 1'b1;
         loadHit = {assembly.rtr, 3'(idx1)};
      end else if (any0 || any1) begin
         ovfEvt = 1'b1;
      end
      if (mode[0] == `MODE_ANY && !acc0 && endErr) loadHit = {assembly.rtr, 3'h0};
   end

   ////////////////////////////////////////////////////////////////////////
   // assembly state machine, always free for the next frame
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= IDLE;
      end else begin
         case (state)
            IDLE:    if (frameStart) state <= ASSEM;
            ASSEM:   if (frameDone || frameError) state <= MOVE;
            MOVE:    state <= frameStart ? ASSEM : IDLE;
            default: state <= IDLE;
         endcase
      end
   end

   // capture from the protocol engine while assembling
   always_ff @(posedge clk) begin
      if (srst) begin
         assembly <= '0;
      end else if (frameStart || state == ASSEM) begin
         assembly <= frameIn;
      end
   end

   slot_mem #(
      .SLOTS(2)
   ) u_mem (
      .clk     (clk),
      .wrEn    (load),
      .wrSlot  (loadSlot),
      .wrFrame (assembly),
      .rdSlot  (paddr[6]),
      .rdWord  (paddr[3:2]),
      .rdData  (memData)
   );

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   assign access    = psel && penable;
   assign wrReq     = access && pwrite && pready;
   assign slotRd    = paddr >= `ADDR_SLOT0 && paddr < `ADDR_SLOT1 + 12'h010;
   assign writeFull = wrReq && paddr == `ADDR_FLAGS;
   assign clrFull   = writeFull ? ~pwdata[1:0] : 2'b00;

   // reads of the slot store take one extra cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         rdPhase <= 1'b0;
      end else begin
         rdPhase <= access && !pwrite && slotRd && !rdPhase;
      end
   end
   assign pready  = !(access && !pwrite && slotRd && !rdPhase);
   assign pslverr = access && regErr && !slotRd;

   // register read mux
   always_comb begin
      regData = 32'h0;
      regErr  = 1'b0;
      if (paddr == `ADDR_CTRL0) begin
         regData = {25'h0, mode[0], 1'b0, hitInfo[0][3], rollover, rollover, hitInfo[0][0]};
      end else if (paddr == `ADDR_CTRL1) begin
         regData = {25'h0, mode[1], 1'b0, hitInfo[1]};
      end else if (paddr == `ADDR_FLAGS) begin
         regData = {29'h0, overflow, full};
      end else if (paddr == `ADDR_IRQEN) begin
         regData = {30'h0, irqEn};
      end else if (paddr == `ADDR_MASK0) begin
         regData = mask[0];
      end else if (paddr == `ADDR_MASK1) begin
         regData = mask[1];
      end else if (paddr >= `ADDR_FILT0 && paddr < `ADDR_FILT0 + 12'(4 * NFILT)) begin
         regData = filt[paddr[4:2]];
      end else begin
         regErr = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         prdata <= 32'h0;
      end else if (psel && !pwrite) begin
         prdata <= slotRd ? memData : regData;
      end
   end
   // read data lands with pready on slot reads
   ////////////////////////////////////////////////////////////////////////
   // configuration writes
   always_ff @(posedge clk) begin
      if (srst) begin
         mode[0]  <= `MODE_ALL;
         mode[1]  <= `MODE_ALL;
         rollover <= 1'b0;
         irqEn    <= 2'b00;
         mask[0]  <= 32'h0;
         mask[1]  <= 32'h0;
         for (int i = 0; i < NFILT; i++) filt[i] <= 32'h0;
      end else if (wrReq) begin
         if (paddr == `ADDR_CTRL0) begin
            mode[0]  <= pwdata[`CTRL_MODE_LSB +: 2];
            rollover <= pwdata[`CTRL_ROLL_BIT];
         end else if (paddr == `ADDR_CTRL1) begin
            mode[1]  <= pwdata[`CTRL_MODE_LSB +: 2];
         end else if (paddr == `ADDR_IRQEN) begin
            irqEn    <= pwdata[1:0];
         end else if (paddr == `ADDR_MASK0) begin
            mask[0]  <= pwdata;
         end else if (paddr == `ADDR_MASK1) begin
            mask[1]  <= pwdata;
         end else if (paddr >= `ADDR_FILT0 && paddr < `ADDR_FILT0 + 12'(4 * NFILT)) begin
            filt[paddr[4:2]] <= pwdata;
         end
      end
   end

   // full flags: set wins over a host clear
   always_ff @(posedge clk) begin
      if (srst) begin
         full <= 2'b00;
      end else begin
         for (int s = 0; s < 2; s++) begin
            if (load && loadSlot == 1'(s)) full[s] <= 1'b1;
            else if (clrFull[s]) full[s] <= 1'b0;
         end
      end
   end

   // overflow: write one to bit 2 clears, event wins
   always_ff @(posedge clk) begin
      if (srst) begin
         overflow <= 1'b0;
      end else if (ovfEvt) begin
         overflow <= 1'b1;
      end else if (writeFull && pwdata[`FLAG_OVF_BIT]) begin
         overflow <= 1'b0;
      end
   end

   // filter hit and remote report per slot
   always_ff @(posedge clk) begin
      if (srst) begin
         hitInfo[0] <= 4'h0;
         hitInfo[1] <= 4'h0;
      end else if (load) begin
         hitInfo[loadSlot] <= loadHit;
      end
   end

   // active low interrupt from enabled full slots
   assign irq_out_n = !(|(full & irqEn));
endmodule : can_rx_buffer

//--- test/can_rx_checker_assertions.sv
// port checker for the receive buffering block
`timescale 1ns/1ps
`include "can_rx_cfg.svh"
module can_rx_checker
   import can_rx_pkg::*;
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        frameStart,
   input wire frame_t      frameIn,
   input wire logic        frameDone,
   input wire logic        frameError,
   input wire logic        irq_out_n,
   input wire logic        overflow
);
   logic wrFlags;
   logic wrIrqEn;
   // host writes that may raise or drop the interrupt
   assign wrFlags = psel && penable && pwrite && pready && paddr == `ADDR_FLAGS;
   assign wrIrqEn = psel && penable && pwrite && pready && paddr == `ADDR_IRQEN;
   ////////////////////////////////////////////////////////////////////////////
   a_ovf_cause: assert property (@(posedge clk) disable iff (srst)
      $rose(overflow) |-> $past(frameDone || frameError))
      else $error("overflow rose without a frame end");
   a_ovf_sticky: assert property (@(posedge clk) disable iff (srst)
      overflow && !(wrFlags && pwdata[`FLAG_OVF_BIT]) |=> overflow)
      else $error("overflow dropped without a clear");
   a_irq_fall: assert property (@(posedge clk) disable iff (srst)
      $fell(irq_out_n) |-> $past(frameDone || frameError) || $past(wrIrqEn))
      else $error("interrupt without reception");
   a_irq_lockout: assert property (@(posedge clk) disable iff (srst)
      $rose(irq_out_n) |-> $past(srst) || $past(wrFlags || wrIrqEn))
      else $error("full state released without host write");
   a_slot_wait: assert property (@(posedge clk) disable iff (srst)
      psel && !penable && !pwrite && paddr >= `ADDR_SLOT0 && paddr < 12'h150
      |=> !pready ##1 pready)
      else $error("slot read wait state wrong");
   a_reg_nowait: assert property (@(posedge clk) disable iff (srst)
      psel && penable && paddr < `ADDR_SLOT0 |-> pready)
      else $error("register access waited");
   a_unmapped_err: assert property (@(posedge clk) disable iff (srst)
      psel && penable && paddr > 12'h034 && paddr < `ADDR_SLOT0 |-> pslverr)
      else $error("unmapped access not refused");
   a_reset_quiet: assert property (@(posedge clk)
      srst |=> irq_out_n && !overflow && pready)
      else $error("outputs not quiet after reset");
endmodule : can_rx_checker
bind can_rx_buffer can_rx_checker chk (.clk(clk), .srst(srst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .frameStart(frameStart),
   .frameIn(frameIn), .frameDone(frameDone), .frameError(frameError),
   .irq_out_n(irq_out_n), .overflow(overflow));

//--- test/can_engine_model.sv
// protocol engine model handing frames to the receive block
`timescale 1ns/1ps
module can_engine_model
   import can_rx_pkg::*;
(
   input  wire logic   clk,
   output      logic   frameStart,
   output      frame_t frameIn,
   output      logic   frameDone,
   output      logic   frameError
);
   // idle outputs at time zero
   initial begin
      frameStart = 1'b0;
      frameDone  = 1'b0;
      frameError = 1'b0;
      frameIn    = '0;
   end
   // start, then done or error, then idle controls with the inverted frame left on frameIn
   task automatic send(input frame_t f, input logic err);
      @(posedge clk);
      frameStart <= 1'b1;
      frameIn    <= f;
      @(posedge clk);
      frameStart <= 1'b0;
      frameDone  <= !err;
      frameError <= err;
      @(posedge clk);
      frameDone  <= 1'b0;
      frameError <= 1'b0;
      frameIn    <= ~f;
      repeat (3) @(posedge clk);
   endtask : send
endmodule : can_engine_model

//--- test/can_receive_buffering_tb.sv
// self-checking bench for the receive buffering block
`timescale 1ns/1ps
`include "can_rx_cfg.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   $display("unexpected %s exp %h got %h", nm, e, g); n_mismatch++; end end
module can_receive_buffering_tb
   import can_rx_pkg::*;
;
   logic        clk, srst, psel, penable, pwrite, pready, pslverr, err;
   logic        frameStart, frameDone, frameError, irq_out_n, overflow;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   frame_t      frameIn;
   frame_t      fa = {1'b0, 1'b0, 4'h8, 29'h123, 64'h1122334455667788};
   frame_t      fb = {1'b0, 1'b0, 4'h2, 29'h456, 64'ha5a5};
   frame_t      fc = {1'b1, 1'b1, 4'h0, 29'h1abcdef, 64'h0};
   frame_t      fd = {1'b0, 1'b0, 4'h1, 29'h7ff, 64'h0f};
   frame_t      fe = {1'b0, 1'b0, 4'h0, 29'h12f, 64'h0};
   int          n_mismatch, n_compared, cyc;
   can_rx_buffer DUT (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .frameStart(frameStart),
      .frameIn(frameIn), .frameDone(frameDone), .frameError(frameError),
      .irq_out_n(irq_out_n), .overflow(overflow));
   can_engine_model eng (.clk(clk), .frameStart(frameStart), .frameIn(frameIn),
      .frameDone(frameDone), .frameError(frameError));
   task automatic end_of_test();
      if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   // one apb transfer, data and error taken at the ready edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic chk(input string nm, input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      `CHK(nm, e, rd)
   endtask : chk
   task automatic chk_slot(input logic [11:0] b, input frame_t f);
      chk("slot id", b, {3'h0, f.id});
      chk("slot fmt", b + 12'h4, {26'h0, f.ext, f.rtr, f.dlc});
      chk("slot lo", b + 12'h8, f.data[31:0]);
      chk("slot hi", b + 12'hc, f.data[63:32]);
   endtask : chk_slot
   // clock and hang limit
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   // main sequence
   initial begin
      {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      chk("flags", `ADDR_FLAGS, 32'h0);
      chk("unmapped", 12'h0f0, 32'h0);
      `CHK("slverr", 1'b1, err)
      xfer(1'b1, `ADDR_MASK0, 32'h1fffffff);
      xfer(1'b1, `ADDR_MASK1, 32'h1fffffff);
      xfer(1'b1, `ADDR_FILT0, 32'h123);
      xfer(1'b1, `ADDR_FILT0 + 12'h4, 32'h456);
      xfer(1'b1, `ADDR_FILT0 + 12'h8, 32'h123);
      xfer(1'b1, `ADDR_FILT0 + 12'hc, 32'h81abcdef);
      xfer(1'b1, `ADDR_IRQEN, 32'h3);
      eng.send(fa, 1'b0);
      chk("flags", `ADDR_FLAGS, 32'h1);
      chk_slot(`ADDR_SLOT0, fa);
      `CHK("irq", 1'b0, irq_out_n)
      xfer(1'b1, `ADDR_FLAGS, 32'h2);
      // the clear lands at the ready edge, look one edge later
      @(posedge clk);
      `CHK("irq", 1'b1, irq_out_n)
      eng.send(fb, 1'b0);
      chk("ctrl0", `ADDR_CTRL0, 32'h1);
      chk_slot(`ADDR_SLOT0, fb);
      eng.send(fa, 1'b0);
      chk("flags", `ADDR_FLAGS, 32'h3);
      chk("ctrl1", `ADDR_CTRL1, 32'h2);
      chk_slot(`ADDR_SLOT0, fb);
      eng.send(fd, 1'b0);
      eng.send(fa, 1'b0);
      chk("flags", `ADDR_FLAGS, 32'h7);
      chk_slot(`ADDR_SLOT1, fa);
      xfer(1'b1, `ADDR_FLAGS, 32'h4);
      @(posedge clk);
      `CHK("ovf", 1'b0, overflow)
      xfer(1'b1, `ADDR_CTRL1, 32'h20);
      eng.send(fc, 1'b0);
      chk("flags", `ADDR_FLAGS, 32'h0);
      xfer(1'b1, `ADDR_CTRL1, 32'h40);
      eng.send(fc, 1'b0);
      chk("ctrl1", `ADDR_CTRL1, 32'h4b);
      chk_slot(`ADDR_SLOT1, fc);
      xfer(1'b1, `ADDR_FLAGS, 32'h0);
      eng.send(fd, 1'b0);
      chk("flags", `ADDR_FLAGS, 32'h0);
      xfer(1'b1, `ADDR_CTRL0, 32'h4);
      eng.send(fa, 1'b0);
      eng.send(fb, 1'b0);
      chk("flags", `ADDR_FLAGS, 32'h3);
      chk_slot(`ADDR_SLOT1, fb);
      xfer(1'b1, `ADDR_FLAGS, 32'h0);
      xfer(1'b1, `ADDR_CTRL0, 32'h60);
      eng.send(fd, 1'b1);
      chk("flags", `ADDR_FLAGS, 32'h1);
      chk_slot(`ADDR_SLOT0, fd);
      xfer(1'b1, `ADDR_CTRL0, 32'h0);
      // masked low id bits let a near identifier through
      xfer(1'b1, `ADDR_FLAGS, 32'h0);
      xfer(1'b1, `ADDR_MASK0, 32'h1ffffff0);
      eng.send(fe, 1'b0);
      chk("flags", `ADDR_FLAGS, 32'h1);
      chk_slot(`ADDR_SLOT0, fe);
      end_of_test();
   end
endmodule : can_receive_buffering_tb
